// ===== verif/dwc_core_model.sv
// far side: analog core that logs each update, and the sync pin source
// assumes updates are one-cycle pulses qualified on the rising edge
module dwc_core_model (
  input  wire logic        clk_sys,
  input  wire logic [11:0] coreData,
  input  wire logic        coreUpdate,
  output logic             syncIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] vals[$];
  int          stamps[$];
  int          cyc = 0;
  initial syncIn = 1'b0;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (coreUpdate === 1'b1) begin
      vals.push_back(coreData);
      stamps.push_back(cyc);
    end
  end
  // long enough on each level to pass the pin synchroniser
  task automatic pulse();
    repeat (4) @(posedge clk_sys);
    syncIn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    syncIn <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask
endmodule // dwc_core_model

// ===== verif/dwc_waveform_ctrl_bench.sv
// bench: random fifo data, watermark sweep, sync edges, generator
// assumes dwc_defines.vh on the include path, 40 MHz clock
`include "dwc_defines.vh"
module dwc_waveform_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdVal, d;
  logic [11:0] coreData, expQ[$];
  logic        coreUpdate, analogOut, analogPowerEnable, syncIn;
  logic        fastSettleSetting, dmaRequest;
  integer      seed = 80, miscompares = 0, numChecks = 0, n0, nDiv, k;
  dwc_waveform_ctrl DUT (.clk_sys(clk_sys), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .syncIn(syncIn),
    .coreData(coreData), .coreUpdate(coreUpdate), .analogOut(analogOut),
    .analogPowerEnable(analogPowerEnable),
    .fastSettleSetting(fastSettleSetting), .dmaRequest(dmaRequest));
  dwc_core_model u_core (.clk_sys(clk_sys), .coreData(coreData),
    .coreUpdate(coreUpdate), .syncIn(syncIn));
  // ******************************************************************
  // clock, tasks
  // ******************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g,
                     input string nm);
    numChecks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // ramp length of a one-shot: start, each step below max, then max
  function automatic int rampLen(input int s, input int st, input int mx);
    int n;
    n = 1;
    while (s + st < mx) begin
      s = s + st;
      n++;
    end
    return n + 1;
  endfunction
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rdVal = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_sim();
  end
  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hf, 32'h0};
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, `DWC_CTRL_OFF, 32'h0);
    chk(32'h0, rdVal, "ctrl reset");
    chk(0, {dmaRequest, analogPowerEnable, fastSettleSetting, analogOut},
        "reset outputs");
    bus(1'b0, `DWC_STAT_OFF, 32'h0);
    chk(32'h2, rdVal & 32'h3f, "stat reset");
    bus(1'b0, 8'hfc, 32'h0);
    chk(32'h0, rdVal, "unmapped");
    // sync ignored so the fifo only fills; ninth write meets a full fifo
    for (int lv = 0; lv <= 8; lv++) begin
      for (int w = 0; w < 4; w++) begin
        bus(1'b1, `DWC_CTRL_OFF, 32'h222 | (w << 6));
        repeat (3) @(posedge clk_sys);
        chk(lv <= 2 * w, dmaRequest, "dmaRequest");
      end
      d = $random(seed);
      if (lv < 8) expQ.push_back(d[11:0]);
      bus(1'b1, `DWC_DATA_OFF, d);
    end
    bus(1'b0, `DWC_STAT_OFF, 32'h0);
    chk(32'h1, rdVal & 32'h3, "stat full");
    for (k = 0; k < 4; k++) begin
      bus(1'b1, `DWC_CTRL_OFF, 32'h202 | (k << 2));
      n0 = u_core.vals.size();
      u_core.pulse();
      chk((k + 1) / 2, u_core.vals.size() - n0, "edge updates");
    end
    bus(1'b1, `DWC_CTRL_OFF, 32'h200);
    repeat (12) @(posedge clk_sys);
    chk(8, u_core.vals.size(), "internal drain");
    for (k = 0; k < 8; k++)
      chk(expQ[k], u_core.vals[k], "low aligned");
    bus(1'b0, `DWC_STAT_OFF, 32'h0);
    chk(32'h2, rdVal & 32'h3, "stat empty");
    chk(expQ[7] != 12'h0, analogOut, "analogOut");
    bus(1'b1, `DWC_CTRL_OFF, 32'h210);
    bus(1'b1, `DWC_DATA_OFF, 32'habc5);
    repeat (6) @(posedge clk_sys);
    chk(32'habc, coreData, "high aligned");
    // hold filter: second word must wait out the hold count
    k = 8 + $unsigned($random(seed)) % 56;
    bus(1'b1, `DWC_CTRL_OFF, 32'h700 | (k << 16));
    n0 = u_core.vals.size();
    bus(1'b1, `DWC_DATA_OFF, 32'h123);
    bus(1'b1, `DWC_DATA_OFF, 32'h456);
    repeat (80) @(posedge clk_sys);
    chk(k + 1, u_core.stamps[n0 + 1] - u_core.stamps[n0], "hold gap");
    chk(32'h456, u_core.vals[n0 + 1], "hold data");
    chk(3, {analogPowerEnable, fastSettleSetting}, "power speed");
    nDiv = $unsigned($random(seed)) % 4;
    bus(1'b1, `DWC_STEP_OFF, 32'h3);
    bus(1'b1, `DWC_MIN_OFF, 32'h10);
    bus(1'b1, `DWC_MAX_OFF, 32'h40);
    bus(1'b1, `DWC_START_OFF, 32'h22);
    bus(1'b1, `DWC_DIV_OFF, nDiv);
    for (k = 0; k < 4; k++) begin
      n0 = u_core.vals.size();
      bus(1'b1, `DWC_CTRL_OFF, 32'h201 | (k << 11));
      repeat (60 * (nDiv + 1)) @(posedge clk_sys);
      bus(1'b1, `DWC_CTRL_OFF, 32'h200);
      d = u_core.vals[n0 + 2] - u_core.vals[n0 + 1];
      chk(k[0] ? 12'hffd : 12'h003, d[11:0], "step dir");
      chk(nDiv + 1, u_core.stamps[n0 + 2] - u_core.stamps[n0 + 1],
          "refresh gap");
      for (int i = n0; i < u_core.vals.size(); i++)
        chk(1, u_core.vals[i] inside {[12'h10:12'h40]}, "limits");
    end
    // one-shot up on rising sync edges: waits, runs once, holds, reruns
    bus(1'b1, `DWC_CTRL_OFF, 32'h220b);
    n0 = u_core.vals.size();
    repeat (20) @(posedge clk_sys);
    chk(n0, u_core.vals.size(), "no edge no run");
    u_core.pulse();
    repeat (50 * (nDiv + 1)) @(posedge clk_sys);
    chk(rampLen(34, 3, 64), u_core.vals.size() - n0, "one-shot run");
    chk(32'h40, coreData, "one-shot end");
    bus(1'b1, `DWC_MAX_OFF, 32'h30);
    repeat (3) @(posedge clk_sys);
    chk(32'h30, coreData, "clamp");
    n0 = u_core.vals.size();
    u_core.pulse();
    repeat (50 * (nDiv + 1)) @(posedge clk_sys);
    chk(rampLen(34, 3, 48), u_core.vals.size() - n0, "rerun");
    bus(1'b1, `DWC_CTRL_OFF, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk(0, {analogOut, analogPowerEnable}, "powered down");
    end_sim();
  end
endmodule // dwc_waveform_ctrl_bench

// ===== verif/dwc_waveform_ctrl_chk.sv
// checker: bus and core-side output relations of dwc_waveform_ctrl
// assumes it is bound onto the top module, one clock domain
module dwc_waveform_ctrl_chk (
  input logic        clk_sys,
  input logic        rst,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  input logic [31:0] wb_dat_o,
  input logic [11:0] coreData,
  input logic        coreUpdate,
  input logic        analogOut,
  input logic        analogPowerEnable,
  input logic        fastSettleSetting
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ack_one_wait_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> wb_ack_o) else $error("ack not one cycle after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_needs_req_a: assert property (!wb_stb_i |-> !wb_ack_o)
    else $error("ack without request");
  dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  pwr_off_low_a: assert property (($past(analogPowerEnable) == 1'b0
    && !analogPowerEnable) |-> !analogOut) else $error("output not low");
  pwr_on_follow_a: assert property ((analogPowerEnable
    && $past(analogPowerEnable) && $stable(coreData) && coreData != 12'h0)
    |-> analogOut) else $error("output not following core data");
  data_with_upd_a: assert property ($changed(coreData) |-> coreUpdate)
    else $error("core data changed without update pulse");
  cfg_by_write_a: assert property (
    $changed({analogPowerEnable, fastSettleSetting})
    |-> (wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)))
    else $error("setting changed without bus write");
  cover property (wb_ack_o && wb_dat_o != 32'h0);
  cover property (coreUpdate ##1 coreUpdate);
  cover property ($rose(analogOut));
endmodule // dwc_waveform_ctrl_chk

bind dwc_waveform_ctrl dwc_waveform_ctrl_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .coreData(coreData),
  .coreUpdate(coreUpdate), .analogOut(analogOut),
  .analogPowerEnable(analogPowerEnable),
  .fastSettleSetting(fastSettleSetting));

// ===== verilog/dwc_defines.vh
// register map, field positions, reset values and encodings for dwc block
// assumes a classic wishbone slave, 32-bit data, byte addresses
// Overview of operation
// - one-shot ramp with external sync holds end, reruns on sync edge; internal sync reruns at once
// - sync edge select: none, fall, rise, both
// - fifo watermark choices: zero, two, four, six
// - normal mode dma request at or below watermark
// - low aligned format uses bits 11:0
// - high aligned format uses bits 15:4
// - generator stays within limits, reverses or restarts
// - step added or subtracted by direction
// - refresh divider n updates every n+1 clocks
// - hold filter freezes output 0..63 cycles
// - sync source: internal clock or external pin
// - analog power off forces output low
// - mode select: fifo conversion or waveform generator
// - waveform type selects sawtooth, triangle, one-shot
// - repeating waves start on sync edge, direction
// - internal sync: buffered data next cycle
// - generated value clamped to upper limit
// - fifo full and empty flags readable
`ifndef DWC_DEFINES_VH
`define DWC_DEFINES_VH
// ********************************************************************
// register offsets
// ********************************************************************
`define DWC_CTRL_OFF     8'h00
`define DWC_DATA_OFF     8'h04
`define DWC_STEP_OFF     8'h08
`define DWC_MIN_OFF      8'h0c
`define DWC_MAX_OFF      8'h10
`define DWC_START_OFF    8'h14
`define DWC_DIV_OFF      8'h18
`define DWC_STAT_OFF     8'h1c
// ********************************************************************
// control field positions
// ********************************************************************
`define DWC_C_MODE       0
`define DWC_C_SYNCSRC    1
`define DWC_C_EDGE_LO    2
`define DWC_C_EDGE_HI    3
`define DWC_C_FMT        4
`define DWC_C_DMAEN      5
`define DWC_C_WM_LO      6
`define DWC_C_WM_HI      7
`define DWC_C_HOLDEN     8
`define DWC_C_PWR        9
`define DWC_C_SPEED      10
`define DWC_C_WAVE_LO    11
`define DWC_C_WAVE_HI    13
`define DWC_C_HCNT_LO    16
`define DWC_C_HCNT_HI    21
`define DWC_CTRL_RST     32'h0000_0000
// ********************************************************************
// encodings
// ********************************************************************
`define DWC_EDGE_NONE    2'h0
`define DWC_EDGE_FALL    2'h1
`define DWC_EDGE_RISE    2'h2
`define DWC_EDGE_ANY     2'h3
`define DWC_WAVE_SAW0    3'h0
`define DWC_WAVE_SAW1    3'h1
`define DWC_WAVE_TRI0    3'h2
`define DWC_WAVE_TRI1    3'h3
`define DWC_WAVE_ONE0    3'h4
`define DWC_WAVE_ONE1    3'h5
`define DWC_FIFO_DEPTH   8
`define DWC_FIFO_AW      3
`endif

// ===== verilog/dwc_fifo.v
// data fifo of flip-flops, one write port, one read port
// guards itself: writes when full and reads when empty are ignored
`include "dwc_defines.vh"
module dwc_fifo #(
  parameter DEPTH = `DWC_FIFO_DEPTH,
  parameter AW    = `DWC_FIFO_AW
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          wrEn,
  input  wire [15:0]   wrData,
  input  wire          rdEn,
  output wire [15:0]   rdData,
  output wire [AW:0]   level,
  output wire          full,
  output wire          empty
);
  reg [15:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtrQ;
  reg [AW:0] rdPtrQ;
  wire doWr = wrEn & ~full;
  wire doRd = rdEn & ~empty;
  assign level  = wrPtrQ - rdPtrQ;
  assign full   = (level == DEPTH);
  assign empty  = (level == {(AW+1){1'b0}});
  assign rdData = mem[rdPtrQ[AW-1:0]];
  always @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtrQ[AW-1:0]] <= wrData;
    end
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtrQ <= {(AW+1){1'b0}};
      rdPtrQ <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtrQ <= wrPtrQ + 1'b1;
      end
      if (doRd) begin
        rdPtrQ <= rdPtrQ + 1'b1;
      end
    end
  end
endmodule // dwc_fifo

// ===== verilog/dwc_sync_edge.v
// synchroniser and edge detector for the external sync pin
// assumes sync pin is asynchronous to clk_sys
`include "dwc_defines.vh"
module dwc_sync_edge (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       syncPin,
  input  wire [1:0] edgeSel,
  output reg        syncEvent
);
  reg s1Q;
  reg s2Q;
  reg s3Q;
  reg stableQ;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1Q       <= 1'b0;
      s2Q       <= 1'b0;
      s3Q       <= 1'b0;
      stableQ   <= 1'b0;
      syncEvent <= 1'b0;
    end else begin
      s1Q <= syncPin;
      s2Q <= s1Q;
      s3Q <= s2Q;
      syncEvent <= 1'b0;
      // a change counts only once two later stages agree
      if (s2Q == s3Q && s3Q != stableQ) begin
        stableQ <= s3Q;
        case (edgeSel)
          `DWC_EDGE_NONE: syncEvent <= 1'b0;
          `DWC_EDGE_FALL: syncEvent <= ~s3Q;
          `DWC_EDGE_RISE: syncEvent <= s3Q;
          default:        syncEvent <= 1'b1;
        endcase
      end
    end
  end
endmodule // dwc_sync_edge

// ===== verilog/dwc_waveform_ctrl.v
// digital control of a 12-bit converter: fifo mode and waveform mode
// assumes classic wishbone master, async sync pin, analog core outside
`include "dwc_defines.vh"
module dwc_waveform_ctrl (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        syncIn,
  output reg  [11:0] coreData,
  output reg         coreUpdate,
  output reg         analogOut,
  output reg         analogPowerEnable,
  output reg         fastSettleSetting,
  output reg         dmaRequest
);
  // ******************************************************************
  // registers
  // ******************************************************************
  reg  [31:0] ctrl_q;
  reg  [15:0] stepIncrement_q;
  reg  [15:0] lowerLimit_q;
  reg  [15:0] upperLimit_q;
  reg  [15:0] initialLevel_q;
  reg  [15:0] refreshDivider_q;
  wire        modeGen     = ctrl_q[`DWC_C_MODE];
  wire        syncExt     = ctrl_q[`DWC_C_SYNCSRC];
  wire [1:0]  edgeSel     = ctrl_q[`DWC_C_EDGE_HI:`DWC_C_EDGE_LO];
  wire        fmtHigh     = ctrl_q[`DWC_C_FMT];
  wire        dmaEn       = ctrl_q[`DWC_C_DMAEN];
  wire [1:0]  wmSel       = ctrl_q[`DWC_C_WM_HI:`DWC_C_WM_LO];
  wire        holdEn      = ctrl_q[`DWC_C_HOLDEN];
  wire [2:0]  waveType    = ctrl_q[`DWC_C_WAVE_HI:`DWC_C_WAVE_LO];
  wire [5:0]  holdCount   = ctrl_q[`DWC_C_HCNT_HI:`DWC_C_HCNT_LO];

  // pick the 12 significant bits of a word per data format
  function [11:0] align12;
    input [15:0] w;
    input        hi;
    begin
      if (hi) begin
        align12 = w[15:4];
      end else begin
        align12 = w[11:0];
      end
    end
  endfunction

  // ******************************************************************
  // bus slave
  // ******************************************************************
  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire busWr  = busReq & wb_we_i;
  wire dataWr = busWr & (wb_adr_i == `DWC_DATA_OFF) & wb_sel_i[0];
  wire fifoFull;
  wire fifoEmpty;
  wire [`DWC_FIFO_AW:0] fifoLevel;
  wire [15:0] fifoOut;
  reg  fifoRd;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // byte-masked update of a 16-bit register; lanes 2 and 3 do not apply
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  sel;
    begin
      merge16 = old;
      if (sel[0]) begin
        merge16[7:0] = nw[7:0];
      end
      if (sel[1]) begin
        merge16[15:8] = nw[15:8];
      end
    end
  endfunction

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o         <= 1'b0;
      wb_dat_o         <= 32'h0000_0000;
      ctrl_q           <= `DWC_CTRL_RST;
      stepIncrement_q  <= 16'h0000;
      lowerLimit_q     <= 16'h0000;
      upperLimit_q     <= 16'h0000;
      initialLevel_q   <= 16'h0000;
      refreshDivider_q <= 16'h0000;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= 32'h0000_0000;
      if (busWr) begin
        case (wb_adr_i)
          `DWC_CTRL_OFF:  ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i)
                                    & 32'h003f_7fff;
          `DWC_STEP_OFF:  stepIncrement_q <= merge16(stepIncrement_q,
            wb_dat_i[15:0], wb_sel_i[1:0]);
          `DWC_MIN_OFF:   lowerLimit_q <= merge16(lowerLimit_q,
            wb_dat_i[15:0], wb_sel_i[1:0]);
          `DWC_MAX_OFF:   upperLimit_q <= merge16(upperLimit_q,
            wb_dat_i[15:0], wb_sel_i[1:0]);
          `DWC_START_OFF: initialLevel_q <= merge16(initialLevel_q,
            wb_dat_i[15:0], wb_sel_i[1:0]);
          `DWC_DIV_OFF:   refreshDivider_q <= merge16(refreshDivider_q,
            wb_dat_i[15:0], wb_sel_i[1:0]);
          default: ;
        endcase
      end else if (busReq) begin
        case (wb_adr_i)
          `DWC_CTRL_OFF:  wb_dat_o <= ctrl_q;
          `DWC_STEP_OFF:  wb_dat_o <= {16'h0000, stepIncrement_q};
          `DWC_MIN_OFF:   wb_dat_o <= {16'h0000, lowerLimit_q};
          `DWC_MAX_OFF:   wb_dat_o <= {16'h0000, upperLimit_q};
          `DWC_START_OFF: wb_dat_o <= {16'h0000, initialLevel_q};
          `DWC_DIV_OFF:   wb_dat_o <= {16'h0000, refreshDivider_q};
          `DWC_STAT_OFF:  wb_dat_o <= {20'h00000, coreData[11:8],
                                       2'b00, fifoLevel,
                                       fifoEmpty, fifoFull};
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ******************************************************************
  // fifo mode
  // ******************************************************************
  dwc_fifo #(
    .DEPTH (`DWC_FIFO_DEPTH),
    .AW    (`DWC_FIFO_AW)
  ) uFifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wrEn    (dataWr),
    .wrData  (wb_dat_i[15:0]),
    .rdEn    (fifoRd),
    .rdData  (fifoOut),
    .level   (fifoLevel),
    .full    (fifoFull),
    .empty   (fifoEmpty)
  );

  wire syncEvent;
  dwc_sync_edge uSync (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .syncPin   (syncIn),
    .edgeSel   (edgeSel),
    .syncEvent (syncEvent)
  );

  // watermark is twice the select: 0, 2, 4 or 6 entries
  wire [`DWC_FIFO_AW:0] wmLevel = {1'b0, wmSel, 1'b0};
  // internal source updates each clock, else on the chosen edge
  wire updTick = syncExt ? syncEvent : 1'b1;

  // ******************************************************************
  // waveform generator
  // ******************************************************************
  reg  [15:0] divCnt_q;
  reg  [15:0] wave_q;
  reg         dirUp_q;
  reg         running_q;
  reg         genLive_q;
  wire refresh = (divCnt_q == refreshDivider_q);
  wire isTri   = (waveType == `DWC_WAVE_TRI0) |
                 (waveType == `DWC_WAVE_TRI1);
  wire isOne   = (waveType == `DWC_WAVE_ONE0) |
                 (waveType == `DWC_WAVE_ONE1);
  wire startUp = (waveType == `DWC_WAVE_SAW0) |
                 (waveType == `DWC_WAVE_TRI0) |
                 (waveType == `DWC_WAVE_ONE0);
  wire [16:0] upSum  = {1'b0, wave_q} + {1'b0, stepIncrement_q};
  wire [16:0] dnDiff = {1'b0, wave_q} - {1'b0, stepIncrement_q};
  wire hitMax = upSum[16] | (upSum[15:0] >= upperLimit_q);
  wire hitMin = dnDiff[16] | (dnDiff[15:0] <= lowerLimit_q);
  wire genStart = modeGen & (syncExt ? syncEvent : ~running_q);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divCnt_q  <= 16'h0000;
      wave_q    <= 16'h0000;
      dirUp_q   <= 1'b1;
      running_q <= 1'b0;
      genLive_q <= 1'b0;
    end else if (!modeGen) begin
      divCnt_q  <= 16'h0000;
      running_q <= 1'b0;
      // leaving the generator unlinks wave_q from the core
      genLive_q <= 1'b0;
    end else if (genStart) begin
      // an active sync edge, or with internal sync a stopped generator, (re)starts the pattern
      wave_q    <= initialLevel_q;
      dirUp_q   <= startUp;
      running_q <= 1'b1;
      genLive_q <= 1'b1;
      divCnt_q  <= 16'h0000;
    end else if (running_q) begin
      divCnt_q <= refresh ? 16'h0000 : divCnt_q + 16'h0001;
      if (refresh) begin
        if (dirUp_q) begin
          if (hitMax) begin
            wave_q <= upperLimit_q;
            if (isTri) begin
              dirUp_q <= 1'b0;
            end else if (isOne) begin
              running_q <= 1'b0;
            end else begin
              wave_q <= lowerLimit_q;
            end
          end else begin
            wave_q <= upSum[15:0];
          end
        end else begin
          if (hitMin) begin
            wave_q <= lowerLimit_q;
            if (isTri) begin
              dirUp_q <= 1'b1;
            end else if (isOne) begin
              running_q <= 1'b0;
            end else begin
              wave_q <= upperLimit_q;
            end
          end else begin
            wave_q <= dnDiff[15:0];
          end
        end
      end
    end
  end

  wire [15:0] waveClamp = (wave_q > upperLimit_q) ? upperLimit_q
                                                   : wave_q;

  // ******************************************************************
  // output stage with hold filter
  // ******************************************************************
  reg  [5:0]  hold_q;
  reg  [11:0] nextData;
  reg         nextValid;
  always @* begin
    fifoRd    = 1'b0;
    nextData  = coreData;
    nextValid = 1'b0;
    if (hold_q == 6'h00) begin
      if (modeGen) begin
        // a value left from an earlier run must not reach the core
        if (genLive_q) begin
          nextData  = align12(waveClamp, fmtHigh);
          nextValid = (nextData != coreData);
        end
      end else if (updTick && !fifoEmpty) begin
        fifoRd    = 1'b1;
        nextData  = align12(fifoOut, fmtHigh);
        nextValid = 1'b1;
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      coreData          <= 12'h000;
      coreUpdate        <= 1'b0;
      hold_q            <= 6'h00;
      analogOut         <= 1'b0;
      analogPowerEnable <= 1'b0;
      fastSettleSetting <= 1'b0;
      dmaRequest        <= 1'b0;
    end else begin
      coreUpdate <= nextValid;
      if (nextValid) begin
        coreData <= nextData;
        hold_q   <= holdEn ? holdCount : 6'h00;
      end else if (hold_q != 6'h00) begin
        hold_q <= hold_q - 6'h01;
      end
      analogPowerEnable <= ctrl_q[`DWC_C_PWR];
      fastSettleSetting <= ctrl_q[`DWC_C_SPEED];
      // powered down core output is pulled low
      analogOut <= ctrl_q[`DWC_C_PWR] & (|coreData);
      dmaRequest <= ~modeGen & dmaEn & (fifoLevel <= wmLevel);
    end
  end
endmodule // dwc_waveform_ctrl
